// *** rtl/reset_and_bus_id_control.v ***
// Purpose: Bus identity register and self-clearing software reset register
// Assumes: I2C slave on scl/sda pins oversampled by clk; strap level is a pin
// Notes:   Strap loads once the pin synchroniser has settled
`timescale 1ns/1ps
`default_nettype none
`include "reset_id_map.vh"

module reset_and_bus_id_control (
    input  wire       clk,
    input  wire       rst,
    input  wire [6:0] address_strap_pin,
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output wire       sda_oe_n,
    output reg        video_input_reset,
    output reg        full_digital_reset,
    output reg        core_reset_keep_regs,
    output reg        restore_listed_regs,
    output wire [6:0] active_bus_address
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    wire [8:0] pins_s;

    pin_sync #(.W(9)) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({address_strap_pin, scl_in, sda_in}),
        .q   (pins_s)
    );

    wire [6:0] strap_s = pins_s[8:2];
    wire       scl_s   = pins_s[1];
    wire       sda_s   = pins_s[0];

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg  [6:0] own_bus_address_r;
    reg        address_source_select_r;
    reg  [6:0] strap_addr_r;
    reg        strap_loaded_r;
    reg  [`RESET_CNT_W-1:0] pulse_cnt_r;
    reg  [2:0] pulse_kind_r;
    reg  [1:0] sync_wait_r;
    localparam [31:0] PULSE_LOAD = `RESET_PULSE_CYC;

    // strap address unless source select is 1
    assign active_bus_address = address_source_select_r ? own_bus_address_r
                                                        : strap_addr_r;

    // ****************************************************************
    // I2C slave
    // ****************************************************************
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_AACK = 3'd2;
    localparam ST_DATA = 3'd3;
    localparam ST_DACK = 3'd4;
    localparam ST_READ = 3'd5;
    localparam ST_RACK = 3'd6;
    localparam ST_SKIP = 3'd7;

    reg [2:0] state_r;
    reg       scl_d_r;
    reg       sda_d_r;
    reg [7:0] shift_r;
    reg [3:0] bitcnt_r;
    reg [7:0] ptr_r;
    reg       have_ptr_r;
    reg       rnw_r;
    reg       drive_low_r;
    reg [7:0] rdata_r;

    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;
    wire start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;

    assign sda_out  = 1'b0;
    assign sda_oe_n = ~drive_low_r;

    wire [7:0] reset_reg_view = `RST_SOFTWARE_RESET_CONTROL;

    always @* begin
        case (ptr_r)
            `OFS_BUS_IDENTITY_ADDRESS:
                rdata_r = {own_bus_address_r, address_source_select_r};
            `OFS_SOFTWARE_RESET_CONTROL:
                rdata_r = reset_reg_view;
            default:
                rdata_r = 8'h00;
        endcase
    end

    wire [7:0] byte_in = {shift_r[6:0], sda_s};
    reg        wr_stb;
    reg  [7:0] wr_data;
    reg  [7:0] wr_addr;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r     <= ST_IDLE;
            scl_d_r     <= 1'b1;
            sda_d_r     <= 1'b1;
            shift_r     <= 8'h00;
            bitcnt_r    <= 4'h0;
            ptr_r       <= 8'h00;
            have_ptr_r  <= 1'b0;
            rnw_r       <= 1'b0;
            drive_low_r <= 1'b0;
            wr_stb      <= 1'b0;
            wr_data     <= 8'h00;
            wr_addr     <= 8'h00;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            wr_stb  <= 1'b0;
            if (start_c) begin
                state_r     <= ST_ADDR;
                bitcnt_r    <= 4'h0;
                drive_low_r <= 1'b0;
            end else if (stop_c) begin
                state_r     <= ST_IDLE;
                drive_low_r <= 1'b0;
            end else begin
                case (state_r)
                    ST_ADDR: begin
                        if (scl_rise) begin
                            shift_r  <= byte_in;
                            bitcnt_r <= bitcnt_r + 4'h1;
                        end else if (scl_fall && bitcnt_r == 4'h8) begin
                            if (shift_r[7:1] == active_bus_address) begin
                                drive_low_r <= 1'b1;
                                rnw_r       <= shift_r[0];
                                have_ptr_r  <= 1'b0;
                                state_r     <= ST_AACK;
                            end else begin
                                state_r <= ST_SKIP;
                            end
                        end
                    end
                    ST_AACK: begin
                        if (scl_fall) begin
                            bitcnt_r <= 4'h0;
                            shift_r  <= rdata_r;
                            if (rnw_r) begin
                                drive_low_r <= ~rdata_r[7];
                                state_r     <= ST_READ;
                            end else begin
                                drive_low_r <= 1'b0;
                                state_r     <= ST_DATA;
                            end
                        end
                    end
                    ST_DATA: begin
                        if (scl_rise) begin
                            shift_r  <= byte_in;
                            bitcnt_r <= bitcnt_r + 4'h1;
                        end else if (scl_fall && bitcnt_r == 4'h8) begin
                            drive_low_r <= 1'b1;
                            state_r     <= ST_DACK;
                            if (!have_ptr_r) begin
                                ptr_r      <= shift_r;
                                have_ptr_r <= 1'b1;
                            end else begin
                                wr_stb  <= 1'b1;
                                wr_addr <= ptr_r;
                                wr_data <= shift_r;
                                ptr_r   <= ptr_r + 8'h01;
                            end
                        end
                    end
                    ST_DACK: begin
                        if (scl_fall) begin
                            drive_low_r <= 1'b0;
                            bitcnt_r    <= 4'h0;
                            state_r     <= ST_DATA;
                        end
                    end
                    ST_READ: begin
                        if (scl_fall) begin
                            bitcnt_r <= bitcnt_r + 4'h1;
                            if (bitcnt_r == 4'h7) begin
                                drive_low_r <= 1'b0;
                                state_r     <= ST_RACK;
                            end else begin
                                shift_r     <= {shift_r[6:0], 1'b0};
                                drive_low_r <= ~shift_r[6];
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            if (sda_s) begin
                                state_r <= ST_SKIP;
                            end else begin
                                ptr_r <= ptr_r + 8'h01;
                            end
                        end else if (scl_fall) begin
                            bitcnt_r    <= 4'h0;
                            shift_r     <= rdata_r;
                            drive_low_r <= ~rdata_r[7];
                            state_r     <= ST_READ;
                        end
                    end
                    ST_SKIP: begin
                        drive_low_r <= 1'b0;
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Register bank and reset pulses
    // ****************************************************************
    wire wr_id  = wr_stb && (wr_addr == `OFS_BUS_IDENTITY_ADDRESS);
    wire wr_rst = wr_stb && (wr_addr == `OFS_SOFTWARE_RESET_CONTROL);
    wire [7:0] rst_bits = wr_data & `RESET_CTRL_WRITE_MASK;
    wire reload = wr_rst &&
        (rst_bits[`FLD_CORE_RESET_KEEP_REGS] || rst_bits[`FLD_FULL_DIGITAL_RESET]);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_wait_r <= 2'b00;
        end else if (sync_wait_r != 2'b11) begin
            sync_wait_r <= sync_wait_r + 2'b01;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            own_bus_address_r       <= 7'h00;
            address_source_select_r <= `RST_BUS_IDENTITY_LSB;
            strap_addr_r            <= 7'h00;
            strap_loaded_r          <= 1'b0;
        end else if ((!strap_loaded_r && sync_wait_r == 2'b10) || reload) begin
            own_bus_address_r       <= strap_s;
            strap_addr_r            <= strap_s;
            address_source_select_r <= `RST_BUS_IDENTITY_LSB;
            strap_loaded_r          <= 1'b1;
        end else if (wr_id) begin
            own_bus_address_r       <= wr_data[7:1];
            address_source_select_r <= wr_data[`FLD_ADDRESS_SOURCE_SELECT];
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pulse_cnt_r          <= {`RESET_CNT_W{1'b0}};
            pulse_kind_r         <= 3'b000;
            video_input_reset    <= 1'b0;
            full_digital_reset   <= 1'b0;
            core_reset_keep_regs <= 1'b0;
            restore_listed_regs  <= 1'b0;
        end else begin
            if (wr_rst && rst_bits != 8'h00) begin
                pulse_cnt_r  <= PULSE_LOAD[`RESET_CNT_W-1:0];
                pulse_kind_r <= {rst_bits[`FLD_VIDEO_INPUT_RESET],
                                 rst_bits[`FLD_FULL_DIGITAL_RESET],
                                 rst_bits[`FLD_CORE_RESET_KEEP_REGS]};
            end else if (pulse_cnt_r != {`RESET_CNT_W{1'b0}}) begin
                pulse_cnt_r <= pulse_cnt_r - 1'b1;
            end else begin
                pulse_kind_r <= 3'b000;
            end
            video_input_reset    <= pulse_kind_r[2];
            full_digital_reset   <= pulse_kind_r[1];
            core_reset_keep_regs <= pulse_kind_r[0];
            restore_listed_regs  <= pulse_kind_r[0];
        end
    end

endmodule // reset_and_bus_id_control

`default_nettype wire

// *** rtl/reset_id_map.vh ***
// Purpose: Offsets, fields, reset values and timing for the reset and bus id bank
// Assumes: 8-bit registers on an I2C-style slave, 100 MHz core clock
// Notes:   Definitions only
`ifndef RESET_ID_MAP_VH
`define RESET_ID_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_BUS_IDENTITY_ADDRESS    8'h00
`define OFS_SOFTWARE_RESET_CONTROL  8'h01

// ****************************************************************
// Field positions
// ****************************************************************
`define FLD_ADDRESS_SOURCE_SELECT   0
`define FLD_CORE_RESET_KEEP_REGS    0
`define FLD_FULL_DIGITAL_RESET      1
`define FLD_VIDEO_INPUT_RESET       4

// ****************************************************************
// Reset values and write mask
// ****************************************************************
`define RST_BUS_IDENTITY_LSB        1'b0
`define RST_SOFTWARE_RESET_CONTROL  8'h00
`define RESET_CTRL_WRITE_MASK       8'h13

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS               10
`define RESET_PULSE_NS              80
`define RESET_PULSE_CYC             ((`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_CNT_W                 4

`endif

// *** rtl/pin_sync.v ***
// Purpose: Two-flop synchroniser for a pin level
// Assumes: Input is asynchronous to clk
// Notes:   First stage read only by the second
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rst,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);

    reg [W-1:0] meta_r;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= {W{1'b0}};
            q      <= {W{1'b0}};
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule // pin_sync

`default_nettype wire

// *** verification/reset_and_bus_id_control_checker.sv ***
// Purpose: Port assertions for the reset and bus id bank
// Assumes: One clock, async active-high reset
// Notes:   Bound to the bank
`timescale 1ns/1ps
`default_nettype none
module reset_and_bus_id_control_checker (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [6:0] address_strap_pin,
    input wire logic       scl_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_n,
    input wire logic       video_input_reset,
    input wire logic       full_digital_reset,
    input wire logic       core_reset_keep_regs,
    input wire logic       restore_listed_regs,
    input wire logic [6:0] active_bus_address
);
// ****
// Properties
// ****
default clocking cb @(posedge clk); endclocking
default disable iff (rst);
sequence s_pulse(x); x[*8] ##1 x ##1 !x; endsequence
property p_drv; $rose(sda_oe_n) |-> !scl_in; endproperty
property p_pair; restore_listed_regs == core_reset_keep_regs; endproperty
property p_vid; $rose(video_input_reset) |-> s_pulse(video_input_reset); endproperty
property p_full; $rose(full_digital_reset) |-> s_pulse(full_digital_reset); endproperty
property p_core; $rose(core_reset_keep_regs) |-> s_pulse(core_reset_keep_regs); endproperty
property p_strap; $rose(core_reset_keep_regs) |-> active_bus_address == address_strap_pin;
endproperty
property p_ack; $fell(sda_oe_n) |-> !scl_in; endproperty
property p_bus; $rose(video_input_reset) || $rose(core_reset_keep_regs) |-> !scl_in;
endproperty
a_drv: assert property (p_drv) else $error("sda release");
a_pair: assert property (p_pair) else $error("restore");
a_vid: assert property (p_vid) else $error("vid pulse");
a_full: assert property (p_full) else $error("full pulse");
a_core: assert property (p_core) else $error("core pulse");
a_strap: assert property (p_strap) else $error("strap");
a_ack: assert property (p_ack) else $error("ack edge");
a_bus: assert property (p_bus) else $error("bus write");
c_vid: cover property ($rose(video_input_reset));
c_core: cover property ($rose(core_reset_keep_regs));
c_ack: cover property ($fell(sda_oe_n));
endmodule // reset_and_bus_id_control_checker
bind reset_and_bus_id_control reset_and_bus_id_control_checker chk_inst (.*);
`default_nettype wire

// *** verification/bus_host.sv ***
// Purpose: Serial bus host for the bank
// Assumes: SDA pulled up, lines move on falling clk
// Notes:   Half period of scl is 10 clk
`timescale 1ns/1ps
`default_nettype none
module bus_host (
    input  wire logic clk,
    input  wire logic sda_line,
    output var  logic scl,
    output var  logic sda_low
);
// ****
// Bus tasks
// ****
initial begin
    scl = 1'b1;
    sda_low = 1'b0;
end
task sl(input logic c, input logic l, input int n);
    scl = c;
    sda_low = l;
    repeat (n) @(negedge clk);
endtask
task start_c;
    sl(scl, 1'b0, 5);
    sl(1'b1, 1'b0, 10);
    sl(1'b1, 1'b1, 10);
    sl(1'b0, 1'b1, 5);
endtask
task stop_c;
    sl(1'b0, 1'b1, 5);
    sl(1'b1, 1'b1, 10);
    sl(1'b1, 1'b0, 10);
endtask
task bit_io(input logic b, output logic r);
    sl(1'b0, ~b, 5);
    sl(1'b1, ~b, 5);
    r = sda_line;
    sl(1'b1, ~b, 5);
    sl(1'b0, ~b, 5);
endtask
task xfer(input logic [7:0] d, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
        bit_io(d[i], q[i]);
    bit_io(1'b1, a);
endtask
// Pointer then data, as the reset command needs
task wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d, output logic ak);
    logic [7:0] q;
    logic       n;
    start_c;
    xfer({a, 1'b0}, q, ak);
    xfer(o, q, n);
    xfer(d, q, n);
    stop_c;
endtask
task rd(input logic [6:0] a, input logic [7:0] o, output logic [7:0] d, output logic ak);
    logic n;
    start_c;
    xfer({a, 1'b0}, d, ak);
    xfer(o, d, n);
    start_c;
    xfer({a, 1'b1}, d, n);
    xfer(8'hff, d, n);
    stop_c;
endtask
endmodule // bus_host
`default_nettype wire

// *** verification/reset_and_bus_id_control_tb.sv ***
// Purpose: Self-checking bench for the reset and bus id bank
// Assumes: Strap fixed after reset
// Notes:   Five fixed then three seeded random reset patterns
`timescale 1ns/1ps
`default_nettype none
`include "reset_id_map.vh"
module reset_and_bus_id_control_tb;
logic       clk;
logic       rst;
logic [6:0] strap;
wire        scl, sda_low, sda_out, sda_oe_n, vid, full, core, rest;
wire  [6:0] act;
wire        sda_line = ~sda_low & (sda_oe_n | sda_out);
int         num_errors = 0, cmp_count = 0, cyc = 0;
logic [7:0] vc = 8'h00, fc = 8'h00, cc = 8'h00, rc = 8'h00;
logic [7:0] pat [5] = '{8'h10, 8'h02, 8'h01, 8'hec, 8'hff};
// ****
// Harness
// ****
reset_and_bus_id_control reset_and_bus_id_control_inst (
    .clk(clk), .rst(rst), .address_strap_pin(strap), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .video_input_reset(vid),
    .full_digital_reset(full), .core_reset_keep_regs(core), .restore_listed_regs(rest),
    .active_bus_address(act));
bus_host bus_host_inst (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end
always @(posedge clk) begin
    cyc++;
    vc += {7'h00, vid};
    fc += {7'h00, full};
    cc += {7'h00, core};
    rc += {7'h00, rest};
    if (cyc == 60000) begin
        num_errors++;
        final_report;
    end
end
task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
        num_errors++;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task final_report;
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
function automatic logic [7:0] plen(input logic b);
    return b ? 8'(`RESET_PULSE_CYC + 1) : 8'h00;
endfunction
initial begin
    logic [6:0] s, p, cur;
    logic [7:0] d, q, e;
    logic       ak;
    rst = 1'b1;
    s = 7'($urandom(2423)) | 7'h40;
    p = s ^ 7'h15;
    strap = s;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    bus_host_inst.rd(s, 8'h00, q, ak);
    chk({7'h00, ak}, 8'h00);
    chk(q, {s, 1'b0});
    bus_host_inst.wr(p, 8'h00, 8'h00, ak);
    chk({7'h00, ak}, 8'h01);
    cur = s;
    for (int k = 0; k < 8; k++) begin
        d = (k < 5) ? pat[k] : 8'($urandom);
        bus_host_inst.wr(cur, 8'h00, {p, 1'b1}, ak);
        chk({1'b0, act}, {1'b0, p});
        bus_host_inst.rd(s, 8'h00, q, ak);
        chk({7'h00, ak}, 8'h01);
        vc = 8'h00;
        fc = 8'h00;
        cc = 8'h00;
        rc = 8'h00;
        bus_host_inst.wr(p, 8'h01, d, ak);
        chk({7'h00, ak}, 8'h00);
        e = (d[1:0] != 2'b00) ? {s, 1'b0} : {p, 1'b1};
        cur = e[7:1];
        if (d[1])
            bus_host_inst.wr(cur, 8'h4f, 8'h02, ak);
        bus_host_inst.rd(cur, 8'h01, q, ak);
        chk(q, 8'h00);
        chk(vc, plen(d[4]));
        chk(fc, plen(d[1]));
        chk(cc, plen(d[0]));
        chk(rc, plen(d[0]));
        bus_host_inst.rd(cur, 8'h00, q, ak);
        chk(q, e);
        chk({1'b0, act}, {1'b0, cur});
    end
    final_report;
end
endmodule // reset_and_bus_id_control_tb
`default_nettype wire
